/* File: src/mipc_pkg.sv */
// Package with register map, field layout, reset values and carrier types for the MMD/PHY slice.
package mipc_pkg;
  localparam logic [7:0] IDX_ACCESS_CTRL = 8'h0d;
  localparam logic [7:0] IDX_ADDR_DATA = 8'h0e;
  localparam logic [7:0] IDX_GIG_CAP = 8'h0f;
  localparam logic [7:0] IDX_LINE_CTRL = 8'h10;
  localparam logic [7:0] IDX_LINE_STATUS = 8'h11;
  localparam logic [9:0] ADDR_ACCESS_CTRL = {IDX_ACCESS_CTRL, 2'b00};
  localparam logic [9:0] ADDR_ADDR_DATA = {IDX_ADDR_DATA, 2'b00};
  localparam logic [9:0] ADDR_GIG_CAP = {IDX_GIG_CAP, 2'b00};
  localparam logic [9:0] ADDR_LINE_CTRL = {IDX_LINE_CTRL, 2'b00};
  localparam logic [9:0] ADDR_LINE_STATUS = {IDX_LINE_STATUS, 2'b00};

  localparam int FUNC_MSB = 15;
  localparam int FUNC_LSB = 14;
  localparam int DEV_MSB = 4;
  localparam int DEV_LSB = 0;
  localparam logic [1:0] FUNC_ADDRESS = 2'h0;
  localparam logic [1:0] FUNC_DATA = 2'h1;
  localparam logic [1:0] FUNC_DATA_INC_RW = 2'h2;
  localparam logic [1:0] FUNC_DATA_INC_WR = 2'h3;
  localparam logic [4:0] DEV_MMD1 = 5'h01;
  localparam logic [4:0] DEV_MMD3 = 5'h03;
  localparam logic [4:0] DEV_MMD7 = 5'h07;
  localparam int NUM_MMD = 3;
  localparam int MMD_DEPTH = 16;

  localparam int XOVER_MSB = 6;
  localparam int XOVER_LSB = 5;
  localparam int CARRIER_ON_TRANSMIT_BIT = 3;
  localparam int SQE_BIT = 2;
  localparam int POL_BIT = 1;
  localparam int JAB_BIT = 0;
  localparam logic [1:0] XOVER_AUTO = 2'h3;
  localparam logic [1:0] XOVER_RESERVED = 2'h2;
  localparam logic [1:0] XOVER_MDIX = 2'h1;
  localparam logic [1:0] XOVER_MDI = 2'h0;
  localparam logic [15:0] GIG_CAP_VALUE = 16'h2000;
  localparam logic [15:0] LINE_CTRL_RESET = 16'h0062;
  localparam logic [15:0] LINE_CTRL_WMASK = 16'h006f;
  localparam logic [15:0] ACCESS_CTRL_RESET = 16'h0000;
  localparam logic [15:0] ACCESS_CTRL_WMASK = 16'hc01f;

  typedef enum logic [1:0] {
    SPEED_10 = 2'b00,
    SPEED_100 = 2'b01,
    SPEED_1000 = 2'b10
  } mipc_speed_type;

  // Line-side settings as the PHY datapath sees them.
  typedef struct packed {
    logic [1:0] pair_crossover_mode;
    logic crs_on_transmit;
    logic crs_on_receive;
    logic heartbeat_test_active;
    logic polarity_auto_allowed;
    logic jabber_detect_active;
  } mipc_line_type;

  // Line state from the datapath: speed, duplex and raw activity.
  typedef struct packed {
    mipc_speed_type speed;
    logic full_duplex;
    logic tx_active;
    logic rx_active;
  } mipc_mode_type;
endpackage

/* File: src/mipc_regs.sv */
// AHB-Lite register slice for indirect MMD access and PHY line control.
module mipc_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire mipc_pkg::mipc_mode_type line_mode,
  output mipc_pkg::mipc_line_type line_ctrl
);
  import mipc_pkg::*;

  typedef struct packed {
    logic wr_pend;
    logic [9:0] wr_addr;
    logic [15:0] access_ctrl;
    logic [15:0] line_reg;
    logic [NUM_MMD-1:0][15:0] mmd_ptr;
    logic [31:0] rdata;
    mipc_line_type line;
  } mipc_state_type;

  mipc_state_type cur_ff;
  mipc_state_type nxt_ff;
  logic [15:0] mmd_mem_ff [NUM_MMD][MMD_DEPTH];
  logic [NUM_MMD-1:0] dev_hit;
  logic mmd_known;
  logic [1:0] sel_idx;
  logic [15:0] cur_ptr;
  logic [15:0] mmd_rdata;
  logic [15:0] aad_rdata;
  logic rd_take;
  logic wr_take;
  logic mem_we;
  logic [3:0] mem_word;
  logic [1:0] func;
  logic [4:0] dev;

  localparam logic [4:0] DEV_CODES [NUM_MMD] = '{DEV_MMD1, DEV_MMD3, DEV_MMD7};

  assign func = cur_ff.access_ctrl[FUNC_MSB:FUNC_LSB];
  assign dev = cur_ff.access_ctrl[DEV_MSB:DEV_LSB];

  // One comparator per supported MMD.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_MMD; gi++) begin : g_dev
      assign dev_hit[gi] = (dev == DEV_CODES[gi]);
    end
  endgenerate

  always_comb begin
    sel_idx = 2'd0;
    if (dev_hit[1]) begin
      sel_idx = 2'd1;
    end else if (dev_hit[2]) begin
      sel_idx = 2'd2;
    end
  end

  assign mmd_known = |dev_hit;
  assign cur_ptr = cur_ff.mmd_ptr[sel_idx];
  // Only the low pointer bits index the implemented MMD storage; upper words alias.
  assign mem_word = cur_ptr[3:0];
  assign mmd_rdata = mmd_known ? mmd_mem_ff[sel_idx][mem_word] : 16'h0000;
  assign aad_rdata = (func == FUNC_ADDRESS) ? (mmd_known ? cur_ptr : 16'h0000)
                                            : mmd_rdata;

  assign rd_take = clk_en && hsel && hready && htrans[1] && !hwrite
                   && (haddr[9:0] == ADDR_ADDR_DATA) && (haddr[31:10] == 22'h0);
  assign wr_take = clk_en && cur_ff.wr_pend && (cur_ff.wr_addr == ADDR_ADDR_DATA);
  assign mem_we = wr_take && (func != FUNC_ADDRESS) && mmd_known;

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.wr_pend = 1'b0;
    if (cur_ff.wr_pend) begin
      if (cur_ff.wr_addr == ADDR_ACCESS_CTRL) begin
        nxt_ff.access_ctrl = hwdata[15:0] & ACCESS_CTRL_WMASK;
      end else if (cur_ff.wr_addr == ADDR_LINE_CTRL) begin
        nxt_ff.line_reg = hwdata[15:0] & LINE_CTRL_WMASK;
      end else if (cur_ff.wr_addr == ADDR_ADDR_DATA && mmd_known) begin
        if (func == FUNC_ADDRESS) begin
          nxt_ff.mmd_ptr[sel_idx] = hwdata[15:0];
        end else if (func != FUNC_DATA) begin
          nxt_ff.mmd_ptr[sel_idx] = cur_ptr + 16'h0001;
        end
      end
    end
    if (rd_take && mmd_known && func == FUNC_DATA_INC_RW) begin
      nxt_ff.mmd_ptr[sel_idx] = cur_ptr + 16'h0001;
    end
    nxt_ff.rdata = 32'h0;
    if (hsel && hready && htrans[1] && !hwrite && haddr[31:10] == 22'h0) begin
      if (haddr[9:0] == ADDR_ACCESS_CTRL) begin
        nxt_ff.rdata = {16'h0, cur_ff.access_ctrl};
      end else if (haddr[9:0] == ADDR_ADDR_DATA) begin
        nxt_ff.rdata = {16'h0, aad_rdata};
      end else if (haddr[9:0] == ADDR_GIG_CAP) begin
        nxt_ff.rdata = {16'h0, GIG_CAP_VALUE};
      end else if (haddr[9:0] == ADDR_LINE_CTRL) begin
        nxt_ff.rdata = {16'h0, cur_ff.line_reg};
      end else if (haddr[9:0] == ADDR_LINE_STATUS) begin
        nxt_ff.rdata = {16'h0, cur_ff.line.crs_on_transmit, cur_ff.line.crs_on_receive,
                        cur_ff.line.heartbeat_test_active, cur_ff.line.polarity_auto_allowed,
                        cur_ff.line.jabber_detect_active, 9'h0, cur_ff.line.pair_crossover_mode};
      end
    end
    if (hsel && hready && htrans[1] && hwrite) begin
      nxt_ff.wr_pend = (haddr[31:10] == 22'h0);
      nxt_ff.wr_addr = haddr[9:0];
    end
    // The reserved crossover code is stored but the line keeps the previous mode.
    if (cur_ff.line_reg[XOVER_MSB:XOVER_LSB] != XOVER_RESERVED) begin
      nxt_ff.line.pair_crossover_mode = cur_ff.line_reg[XOVER_MSB:XOVER_LSB];
    end
    nxt_ff.line.crs_on_transmit = line_mode.tx_active && cur_ff.line_reg[CARRIER_ON_TRANSMIT_BIT]
      && !(line_mode.speed == SPEED_10 && line_mode.full_duplex)
      && line_mode.speed != SPEED_1000;
    nxt_ff.line.crs_on_receive = line_mode.rx_active;
    nxt_ff.line.heartbeat_test_active = cur_ff.line_reg[SQE_BIT] && !line_mode.full_duplex;
    nxt_ff.line.polarity_auto_allowed = cur_ff.line_reg[POL_BIT]
      || line_mode.speed != SPEED_10;
    nxt_ff.line.jabber_detect_active = !cur_ff.line_reg[JAB_BIT]
      && line_mode.speed == SPEED_10;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_ff <= '0;
      cur_ff.access_ctrl <= ACCESS_CTRL_RESET;
      cur_ff.line_reg <= LINE_CTRL_RESET;
      cur_ff.line.pair_crossover_mode <= XOVER_AUTO;
      cur_ff.line.polarity_auto_allowed <= 1'b1;
    end else if (clk_en) begin
      cur_ff <= nxt_ff;
    end
  end

  // MMD storage has no reset, as in a register file macro.
  always_ff @(posedge hclk) begin
    if (mem_we) begin
      mmd_mem_ff[sel_idx][mem_word] <= hwdata[15:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = cur_ff.rdata;
  assign line_ctrl = cur_ff.line;

  AST_FUNC_WMASK: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && cur_ff.wr_pend && cur_ff.wr_addr == ADDR_ACCESS_CTRL |=>
    cur_ff.access_ctrl[13:5] == 9'h0 && cur_ff.access_ctrl[15:14] == $past(hwdata[15:14]))
    else $error("access control write not stored");
  AST_DEV_HIT: assert property (@(posedge hclk) disable iff (!hresetn)
    mmd_known == (dev == DEV_MMD1 || dev == DEV_MMD3 || dev == DEV_MMD7))
    else $error("device decode wrong");
  AST_ADDR_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_take && func == FUNC_ADDRESS && mmd_known |=> cur_ff.mmd_ptr[$past(sel_idx)]
    == $past(hwdata[15:0])) else $error("address write lost");
  AST_NO_INC: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_take || rd_take) && func == FUNC_DATA |=> $stable(cur_ff.mmd_ptr))
    else $error("plain data access moved pointer");
  AST_INC_WR: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_take && mmd_known && func[1] |=> cur_ff.mmd_ptr[$past(sel_idx)]
    == $past(cur_ptr) + 16'h0001) else $error("post increment missed");
  AST_INC_RD_ONLY_RW: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_take && !cur_ff.wr_pend && func == FUNC_DATA_INC_WR |=> $stable(cur_ff.mmd_ptr))
    else $error("read incremented in write-only mode");
  AST_GIG_CAP: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && hsel && hready && htrans[1] && !hwrite && haddr == {22'h0, ADDR_GIG_CAP}
    |=> hrdata == 32'h0000_2000) else $error("capability read wrong");
  AST_SQE_FDX: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && line_mode.full_duplex |=> !line_ctrl.heartbeat_test_active)
    else $error("heartbeat active in full duplex");
  AST_JAB: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && cur_ff.line_reg[JAB_BIT] |=> !line_ctrl.jabber_detect_active)
    else $error("jabber active while disabled");
  AST_XOVER_RSVD: assert property (@(posedge hclk) disable iff (!hresetn)
    line_ctrl.pair_crossover_mode != XOVER_RESERVED)
    else $error("reserved crossover driven");

  COV_ADDR_THEN_DATA: cover property (@(posedge hclk) disable iff (!hresetn)
    wr_take && func == FUNC_ADDRESS ##[1:20] rd_take && func != FUNC_ADDRESS);
  COV_INC_RW: cover property (@(posedge hclk) disable iff (!hresetn)
    rd_take && mmd_known && func == FUNC_DATA_INC_RW);
  COV_XOVER_MDIX: cover property (@(posedge hclk) disable iff (!hresetn)
    line_ctrl.pair_crossover_mode == XOVER_MDIX);
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the indirect MMD access and line control register slice.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import mipc_pkg::*;
  localparam int MAX_CYCLES = 4000;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic clk_en = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  mipc_mode_type line_mode = '{SPEED_10, 1'b0, 1'b0, 1'b0};
  mipc_line_type line_ctrl;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  mipc_regs dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .line_mode(line_mode),
    .line_ctrl(line_ctrl));

  always #50 hclk = ~hclk;

  task automatic close_out();
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles >= MAX_CYCLES) begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The master holds each phase until it sees hready high, never assuming a latency.
  task automatic bus(input logic [9:0] a, input logic wr, input logic [15:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, wd};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [15:0] exp);
    logic [31:0] r;
    bus(a, 1'b0, 16'h0, r);
    chk(r, {16'h0, exp});
  endtask

  // Carrier-sense-on-receive depends on line activity only, so it is masked out here.
  task automatic line_chk(input mipc_mode_type m, input logic [6:0] exp);
    line_mode <= m;
    repeat (3) @(posedge hclk);
    chk({25'h0, line_ctrl & 7'h77}, {25'h0, exp});
  endtask

  task automatic ctl(input logic [1:0] f, input logic [4:0] dev);
    wr(ADDR_ACCESS_CTRL, {f, 9'h0, dev});
  endtask

  task automatic test_reset_and_reserved();
    line_chk('{SPEED_10, 1'b0, 1'b0, 1'b0}, 7'h63);
    rd_chk(ADDR_LINE_CTRL, 16'h0062);
    rd_chk(ADDR_GIG_CAP, 16'h2000);
    rd_chk(ADDR_ACCESS_CTRL, 16'h0000);
    wr(ADDR_ACCESS_CTRL, 16'hffff);
    rd_chk(ADDR_ACCESS_CTRL, 16'hc01f);
    wr(ADDR_GIG_CAP, 16'h0000);
    rd_chk(ADDR_GIG_CAP, 16'h2000);
    rd_chk(10'h200, 16'h0000);
    wr(ADDR_LINE_CTRL, 16'hffff);
    rd_chk(ADDR_LINE_CTRL, 16'h006f);
    // A write made while the clock enable is low must be lost.
    clk_en <= 1'b0;
    wr(ADDR_LINE_CTRL, 16'h0000);
    clk_en <= 1'b1;
    rd_chk(ADDR_LINE_CTRL, 16'h006f);
  endtask

  task automatic test_line();
    line_chk('{SPEED_10, 1'b0, 1'b1, 1'b0}, 7'h76);
    line_chk('{SPEED_10, 1'b1, 1'b1, 1'b0}, 7'h62);
    line_chk('{SPEED_100, 1'b1, 1'b1, 1'b0}, 7'h72);
    line_chk('{SPEED_1000, 1'b0, 1'b1, 1'b0}, 7'h66);
    wr(ADDR_LINE_CTRL, 16'h0020);
    line_chk('{SPEED_10, 1'b0, 1'b0, 1'b0}, 7'h21);
    wr(ADDR_LINE_CTRL, 16'h0040);
    rd_chk(ADDR_LINE_CTRL, 16'h0040);
    line_chk('{SPEED_10, 1'b0, 1'b0, 1'b0}, 7'h21);
    wr(ADDR_LINE_CTRL, 16'h0000);
    line_chk('{SPEED_10, 1'b0, 1'b0, 1'b0}, 7'h01);
  endtask

  task automatic test_mmd(input logic [4:0] dev);
    ctl(FUNC_ADDRESS, dev);
    wr(ADDR_ADDR_DATA, 16'h0005);
    ctl(FUNC_DATA_INC_WR, dev);
    wr(ADDR_ADDR_DATA, {11'h100, dev});
    wr(ADDR_ADDR_DATA, {11'h200, dev});
    ctl(FUNC_ADDRESS, dev);
    wr(ADDR_ADDR_DATA, 16'h0005);
    ctl(FUNC_DATA_INC_RW, dev);
    rd_chk(ADDR_ADDR_DATA, {11'h100, dev});
    rd_chk(ADDR_ADDR_DATA, {11'h200, dev});
    ctl(FUNC_ADDRESS, dev);
    wr(ADDR_ADDR_DATA, 16'h0006);
    ctl(FUNC_DATA, dev);
    rd_chk(ADDR_ADDR_DATA, {11'h200, dev});
    rd_chk(ADDR_ADDR_DATA, {11'h200, dev});
    ctl(FUNC_DATA_INC_WR, dev);
    rd_chk(ADDR_ADDR_DATA, {11'h200, dev});
    rd_chk(ADDR_ADDR_DATA, {11'h200, dev});
  endtask

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    test_reset_and_reserved();
    test_line();
    test_mmd(DEV_MMD1);
    test_mmd(DEV_MMD3);
    test_mmd(DEV_MMD7);
    ctl(FUNC_ADDRESS, DEV_MMD1);
    wr(ADDR_ADDR_DATA, 16'h0005);
    ctl(FUNC_DATA, DEV_MMD1);
    rd_chk(ADDR_ADDR_DATA, 16'h2001);
    close_out();
  end
endmodule
